/* File: hdl/flash_guard_pkg.sv */
/*
  Constants for the flash program/erase host controller: software register
  map, command layout, device register indices, control bit positions, timing.
  Assumes a 100 MHz REF_CLK and a byte-wide register port on the flash device.
*/
package flash_guard_pkg;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SHADOW = 8'h0C;

  localparam int CTRL_PE_REQ_BIT = 0;

  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_REG_LSB  = 2;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_ADDR_LSB = 16;

  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_PIN_BIT     = 2;
  localparam int ST_WAIT_BIT    = 3;
  localparam int ST_RDATA_LSB   = 8;

  localparam logic [1:0] DEV_FLASH_CTRL_ONE = 2'h0;
  localparam logic [1:0] DEV_FLASH_CTRL_TWO = 2'h1;
  localparam logic [1:0] DEV_ERASE_BLOCK    = 2'h2;
  localparam logic [1:0] DEV_RAM_EMULATION  = 2'h3;

  localparam int PROG_BIT        = 0;
  localparam int ERASE_BIT       = 1;
  localparam int PROG_VERIFY_BIT = 2;
  localparam int ERASE_VERIFY_BIT = 3;
  localparam int PROG_SETUP_BIT  = 4;
  localparam int ERASE_SETUP_BIT = 5;
  localparam int REWRITE_EN_BIT  = 6;

  localparam logic [7:0] FCR1_RESET = 8'h00;

  localparam int UNIT_BYTES_LOG2 = 7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOVERY_US   = 100;
  localparam int RECOVERY_CYC  = (RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_REG_WR   = 2'h0,
    OP_REG_RD   = 2'h1,
    OP_FLASH_RD = 2'h2,
    OP_PROGRAM  = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ISSUE = 2'b01,
    S_TAKE  = 2'b11
  } state_t;

endpackage

/* File: hdl/flash_pe_controller.sv */
/*
  Host-side program/erase controller for an on-chip flash array. Software
  issues commands over APB; the controller drives the device's byte-wide
  register port, its flash read port and the program/erase enable pin, and
  refuses commands that would break the device's access discipline.
  Assumes the device returns register and flash read data one cycle after
  the read strobe, and FLASH_EXEC is high while code runs from flash.
*/
`timescale 1ns/1ps
module flash_pe_controller #(
  parameter int ADDR_W          = 16,
  parameter int RECOVERY_CYCLES = flash_guard_pkg::RECOVERY_CYC,
  parameter int SETTLE_CYCLES   = flash_guard_pkg::SETTLE_CYC
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              FLASH_EXEC,
  output logic      [1:0]        DEV_REG_ADDR,
  output logic      [7:0]        DEV_REG_WDATA,
  output logic                   DEV_REG_WE,
  output logic                   DEV_REG_RE,
  input  wire logic [7:0]        DEV_REG_RDATA,
  output logic      [ADDR_W-1:0] FLASH_ADDR,
  output logic                   FLASH_RE,
  input  wire logic [7:0]        FLASH_RDATA,
  output logic                   PROGRAM_ERASE_ENABLE_PIN,
  output logic                   IRQ_MASK_ALL,
  output logic                   BUS_RELEASE_DISABLE
);

  localparam int UNITS = 2 ** (ADDR_W - flash_guard_pkg::UNIT_BYTES_LOG2);
  localparam int UW    = ADDR_W - flash_guard_pkg::UNIT_BYTES_LOG2;

  flash_guard_pkg::state_t state;
  flash_guard_pkg::op_t    cur_op;

  logic              pe_req;
  logic              refused;
  logic [7:0]        shadow;
  logic [7:0]        rdata;
  logic [UNITS-1:0]  unit_done;
  logic [UW-1:0]     prog_unit;
  logic              timer_busy;
  logic              timer_load;
  logic [15:0]       timer_value;

  logic              apb_acc;
  logic              apb_take;
  logic              mapped;
  logic              cmd_wr;
  logic              status_wr;
  flash_guard_pkg::op_t cmd_op;
  logic [1:0]        cmd_reg;
  logic [7:0]        cmd_data;
  logic [ADDR_W-1:0] cmd_addr;
  logic [UW-1:0]     cmd_unit;
  logic [7:0]        next_shadow;
  logic              cmd_bad;
  logic              cmd_ok;
  logic              old_active;
  logic              new_active;

  assign apb_acc   = PSEL && PENABLE;
  assign apb_take  = apb_acc && PREADY;
  assign mapped    = (PADDR == flash_guard_pkg::OFS_CTRL) || (PADDR == flash_guard_pkg::OFS_CMD)
                   || (PADDR == flash_guard_pkg::OFS_STATUS)
                   || (PADDR == flash_guard_pkg::OFS_SHADOW);
  assign cmd_wr    = apb_take && PWRITE && (PADDR == flash_guard_pkg::OFS_CMD);
  assign status_wr = apb_take && PWRITE && (PADDR == flash_guard_pkg::OFS_STATUS);

  assign cmd_op   = flash_guard_pkg::op_t'(PWDATA[flash_guard_pkg::CMD_OP_LSB +: 2]);
  assign cmd_reg  = PWDATA[flash_guard_pkg::CMD_REG_LSB +: 2];
  assign cmd_data = PWDATA[flash_guard_pkg::CMD_DATA_LSB +: 8];
  assign cmd_addr = PWDATA[flash_guard_pkg::CMD_ADDR_LSB +: ADDR_W];
  assign cmd_unit = cmd_addr[ADDR_W-1:flash_guard_pkg::UNIT_BYTES_LOG2];

  // mode bits whose exit starts the recovery wait
  assign old_active = shadow[flash_guard_pkg::PROG_BIT] || shadow[flash_guard_pkg::ERASE_BIT]
                   || shadow[flash_guard_pkg::PROG_VERIFY_BIT]
                   || shadow[flash_guard_pkg::ERASE_VERIFY_BIT];
  assign new_active = next_shadow[flash_guard_pkg::PROG_BIT]
                   || next_shadow[flash_guard_pkg::ERASE_BIT]
                   || next_shadow[flash_guard_pkg::PROG_VERIFY_BIT]
                   || next_shadow[flash_guard_pkg::ERASE_VERIFY_BIT];

  always_comb
  begin
    next_shadow = shadow;
    cmd_bad     = 1'b0;
    unique case (cmd_op)
      flash_guard_pkg::OP_REG_WR:
      begin
        if (cmd_reg == flash_guard_pkg::DEV_FLASH_CTRL_ONE)
        begin
          next_shadow = cmd_data;
          // programming only through the checked program command
          if (cmd_data[flash_guard_pkg::PROG_BIT])
            cmd_bad = 1'b1;
          if ((cmd_data[flash_guard_pkg::REWRITE_EN_BIT] != shadow[flash_guard_pkg::REWRITE_EN_BIT])
              && FLASH_EXEC)
            cmd_bad = 1'b1;
          // bits set with the pin low would block the pin release later
          if (!PROGRAM_ERASE_ENABLE_PIN && (cmd_data != 8'h00))
            cmd_bad = 1'b1;
        end
      end
      flash_guard_pkg::OP_REG_RD:
        cmd_bad = 1'b0;
      flash_guard_pkg::OP_FLASH_RD:
      begin
        if (timer_busy)
          cmd_bad = 1'b1;
        if (shadow[flash_guard_pkg::PROG_BIT] || shadow[flash_guard_pkg::ERASE_BIT])
          cmd_bad = 1'b1;
        if (shadow[flash_guard_pkg::REWRITE_EN_BIT]
            && !(shadow[flash_guard_pkg::PROG_VERIFY_BIT]
                 || shadow[flash_guard_pkg::ERASE_VERIFY_BIT]))
          cmd_bad = 1'b1;
      end
      flash_guard_pkg::OP_PROGRAM:
      begin
        next_shadow = shadow | (8'h01 << flash_guard_pkg::PROG_BIT);
        if (unit_done[cmd_unit])
          cmd_bad = 1'b1;
        if (!shadow[flash_guard_pkg::REWRITE_EN_BIT] || !PROGRAM_ERASE_ENABLE_PIN)
          cmd_bad = 1'b1;
      end
    endcase
  end

  assign cmd_ok = cmd_wr && (state == flash_guard_pkg::S_IDLE) && !cmd_bad;

  // wait timer: recovery wins over settling when both apply
  always_comb
  begin
    timer_load  = 1'b0;
    timer_value = 16'h0000;
    if (cmd_ok && (cmd_op == flash_guard_pkg::OP_REG_WR)
        && (cmd_reg == flash_guard_pkg::DEV_FLASH_CTRL_ONE))
    begin
      if (old_active && !new_active)
      begin
        timer_load  = 1'b1;
        timer_value = 16'(RECOVERY_CYCLES);
      end
      else if (shadow[flash_guard_pkg::REWRITE_EN_BIT]
               && !next_shadow[flash_guard_pkg::REWRITE_EN_BIT])
      begin
        timer_load  = 1'b1;
        timer_value = 16'(SETTLE_CYCLES);
      end
    end
  end

  flash_wait_timer #(
    .W (16)
  ) u_wait (
    .clk        (REF_CLK),
    .rst_n      (RST_N),
    .load       (timer_load),
    .load_value (timer_value),
    .busy       (timer_busy)
  );

  // apb: every access takes one wait cycle so read data comes from a flop
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= apb_acc && !PREADY;
      PSLVERR <= apb_acc && !PREADY && !mapped;
      PRDATA  <= 32'h0000_0000;
      if (apb_acc && !PREADY && !PWRITE)
      begin
        unique case (PADDR)
          flash_guard_pkg::OFS_CTRL:
            PRDATA <= {31'h0000_0000, pe_req};
          flash_guard_pkg::OFS_STATUS:
            PRDATA <= {16'h0000, rdata, 4'h0, timer_busy, PROGRAM_ERASE_ENABLE_PIN, refused,
                       (state != flash_guard_pkg::S_IDLE)};
          flash_guard_pkg::OFS_SHADOW:
            PRDATA <= {24'h00_0000, shadow};
          default:
            PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pe_req <= 1'b0;
    else if (apb_take && PWRITE && (PADDR == flash_guard_pkg::OFS_CTRL))
      pe_req <= PWDATA[flash_guard_pkg::CTRL_PE_REQ_BIT];
  end

  // refusal flag: a new refusal beats a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      refused <= 1'b0;
    else if (cmd_wr && !cmd_ok)
      refused <= 1'b1;
    else if (status_wr && PWDATA[flash_guard_pkg::ST_REFUSED_BIT])
      refused <= 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      shadow <= flash_guard_pkg::FCR1_RESET;
    else if (cmd_ok && ((cmd_op == flash_guard_pkg::OP_PROGRAM)
                        || ((cmd_op == flash_guard_pkg::OP_REG_WR)
                            && (cmd_reg == flash_guard_pkg::DEV_FLASH_CTRL_ONE))))
      shadow <= next_shadow;
  end

  // one flag per programming unit, cleared by any erase start
  generate
    for (genvar u = 0; u < UNITS; u++)
    begin : g_unit
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          unit_done[u] <= 1'b0;
        else if (cmd_ok && (cmd_op == flash_guard_pkg::OP_PROGRAM) && (cmd_unit == UW'(u)))
          unit_done[u] <= 1'b1;
        else if (cmd_ok && (cmd_op == flash_guard_pkg::OP_REG_WR)
                 && (cmd_reg == flash_guard_pkg::DEV_FLASH_CTRL_ONE)
                 && cmd_data[flash_guard_pkg::ERASE_BIT])
          unit_done[u] <= 1'b0;
      end
    end
  endgenerate

  // sequencer: strobe one cycle, take data the next
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state         <= flash_guard_pkg::S_IDLE;
      cur_op        <= flash_guard_pkg::OP_REG_RD;
      prog_unit     <= '0;
      DEV_REG_ADDR  <= 2'h0;
      DEV_REG_WDATA <= 8'h00;
      DEV_REG_WE    <= 1'b0;
      DEV_REG_RE    <= 1'b0;
      FLASH_ADDR    <= '0;
      FLASH_RE      <= 1'b0;
      rdata         <= 8'h00;
    end
    else
    begin
      unique case (state)
        flash_guard_pkg::S_IDLE:
        begin
          if (cmd_ok)
          begin
            state  <= flash_guard_pkg::S_ISSUE;
            cur_op <= cmd_op;
            // byte transfers only, one register per strobe
            DEV_REG_ADDR  <= (cmd_op == flash_guard_pkg::OP_PROGRAM)
                             ? flash_guard_pkg::DEV_FLASH_CTRL_ONE : cmd_reg;
            DEV_REG_WDATA <= (cmd_op == flash_guard_pkg::OP_REG_WR) ? cmd_data : next_shadow;
            DEV_REG_WE    <= (cmd_op == flash_guard_pkg::OP_REG_WR)
                             || (cmd_op == flash_guard_pkg::OP_PROGRAM);
            DEV_REG_RE    <= (cmd_op == flash_guard_pkg::OP_REG_RD);
            FLASH_ADDR    <= cmd_addr;
            FLASH_RE      <= (cmd_op == flash_guard_pkg::OP_FLASH_RD);
            if (cmd_op == flash_guard_pkg::OP_PROGRAM)
              prog_unit <= cmd_unit;
          end
        end
        flash_guard_pkg::S_ISSUE:
        begin
          state      <= flash_guard_pkg::S_TAKE;
          DEV_REG_WE <= 1'b0;
          DEV_REG_RE <= 1'b0;
          FLASH_RE   <= 1'b0;
        end
        flash_guard_pkg::S_TAKE:
        begin
          state <= flash_guard_pkg::S_IDLE;
          if (cur_op == flash_guard_pkg::OP_REG_RD)
            rdata <= DEV_REG_RDATA;
          else if (cur_op == flash_guard_pkg::OP_FLASH_RD)
            rdata <= FLASH_RDATA;
        end
      endcase
    end
  end

  // masks rise before the pin and fall after it
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PROGRAM_ERASE_ENABLE_PIN <= 1'b0;
      IRQ_MASK_ALL             <= 1'b0;
      BUS_RELEASE_DISABLE      <= 1'b0;
    end
    else if (pe_req)
    begin
      IRQ_MASK_ALL        <= 1'b1;
      BUS_RELEASE_DISABLE <= 1'b1;
      if (IRQ_MASK_ALL && BUS_RELEASE_DISABLE)
        PROGRAM_ERASE_ENABLE_PIN <= 1'b1;
    end
    else
    begin
      if ((shadow == 8'h00) && (state == flash_guard_pkg::S_IDLE))
        PROGRAM_ERASE_ENABLE_PIN <= 1'b0;
      if (!PROGRAM_ERASE_ENABLE_PIN)
      begin
        IRQ_MASK_ALL        <= 1'b0;
        BUS_RELEASE_DISABLE <= 1'b0;
      end
    end
  end

  pin_irq_mask_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    PROGRAM_ERASE_ENABLE_PIN |-> IRQ_MASK_ALL && $past(IRQ_MASK_ALL))
    else $error("interrupts unmasked while enable pin high");

  pin_bus_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    PROGRAM_ERASE_ENABLE_PIN |-> BUS_RELEASE_DISABLE)
    else $error("bus release allowed while enable pin high");

  pin_drop_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $fell(PROGRAM_ERASE_ENABLE_PIN) |-> $past(shadow) == 8'h00)
    else $error("enable pin dropped with control bits set");

  swe_no_exec_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $changed(shadow[flash_guard_pkg::REWRITE_EN_BIT]) |-> !$past(FLASH_EXEC))
    else $error("rewrite enable changed during flash execution");

  swe_settle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $fell(shadow[flash_guard_pkg::REWRITE_EN_BIT]) |-> timer_busy [*8])
    else $error("no settling wait after rewrite enable cleared");

  mode_recovery_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $fell(old_active) |-> (timer_busy && !FLASH_RE) [*8])
    else $error("flash read too soon after leaving program mode");

  read_verify_only_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    FLASH_RE && shadow[flash_guard_pkg::REWRITE_EN_BIT]
      |-> shadow[flash_guard_pkg::PROG_VERIFY_BIT] || shadow[flash_guard_pkg::ERASE_VERIFY_BIT])
    else $error("non-verify flash read with rewrite enable set");

  read_no_pe_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    FLASH_RE |-> !shadow[flash_guard_pkg::PROG_BIT] && !shadow[flash_guard_pkg::ERASE_BIT])
    else $error("flash read while program or erase bit set");

  prog_once_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(shadow[flash_guard_pkg::PROG_BIT]) |-> unit_done[prog_unit]
      && !$past(unit_done[cmd_unit]) && (prog_unit == $past(cmd_unit)))
    else $error("programming unit programmed twice without erase");

  byte_strobe_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    DEV_REG_WE |=> !DEV_REG_WE && !DEV_REG_RE)
    else $error("register strobe longer than one byte transfer");

endmodule // flash_pe_controller

/* File: hdl/flash_wait_timer.sv */
/*
  Down-counter that holds busy for a loaded number of cycles.
  Assumes load is a one-cycle pulse; a new load restarts the count.
*/
`timescale 1ns/1ps
module flash_wait_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic              busy
);

  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign busy = (count != '0);

endmodule // flash_wait_timer

/* File: verification/flash_device_model.sv */
/*
  Behavioural flash device: four byte-wide control registers and a flash read port.
  Assumes one-cycle strobes from the controller; each answer stands one cycle.
*/
`timescale 1ns/1ps
module flash_device_model (
  input  wire logic        clk,
  input  wire logic        pin,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] flash_addr,
  input  wire logic        flash_re,
  output logic      [7:0]  flash_rdata
);
  logic [7:0] regs [4] = '{default: 8'h00};

  initial
  begin
    reg_rdata = 8'h00;
    flash_rdata = 8'h00;
  end

  // idle read lines flip so a late capture never sees stale data
  always @(posedge clk)
  begin
    if (reg_we)
      regs[reg_addr] <= (reg_addr == 2'h0 && !pin) ? 8'h00 : reg_wdata;
    reg_rdata <= reg_re ? regs[reg_addr] : ~reg_rdata;
    // array and overlay answer whatever the rewrite-enable bit holds
    flash_rdata <= flash_re ? (flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C) : ~flash_rdata;
  end
endmodule // flash_device_model

/* File: verification/flash_program_erase_guard_bench.sv */
/*
  Self-checking bench for the flash program/erase controller.
  Assumes flash_device_model on the device port and APB reads polled for busy.
*/
`timescale 1ns/1ps
module flash_program_erase_guard_bench;
  logic        ref_clk, rst_n, psel, penable, pwrite, flash_exec;
  logic [7:0]  paddr, dev_reg_wdata, dev_reg_rdata, flash_rdata, fcr, d;
  logic [31:0] pwdata, prdata, last;
  logic        pready, pslverr, dev_reg_we, dev_reg_re, flash_re;
  logic        pin, irq_mask, bus_dis, prev_pin;
  logic [1:0]  dev_reg_addr;
  logic [15:0] flash_addr, a;
  logic [64:0] rdq [$];
  logic [9:0]  devq [$];
  logic [64:0] e;
  int          errors, checks_done, seed;

  flash_pe_controller #(.ADDR_W(16), .RECOVERY_CYCLES(40), .SETTLE_CYCLES(10)) dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FLASH_EXEC(flash_exec), .DEV_REG_ADDR(dev_reg_addr), .DEV_REG_WDATA(dev_reg_wdata),
    .DEV_REG_WE(dev_reg_we), .DEV_REG_RE(dev_reg_re), .DEV_REG_RDATA(dev_reg_rdata),
    .FLASH_ADDR(flash_addr), .FLASH_RE(flash_re), .FLASH_RDATA(flash_rdata),
    .PROGRAM_ERASE_ENABLE_PIN(pin), .IRQ_MASK_ALL(irq_mask), .BUS_RELEASE_DISABLE(bus_dis));

  flash_device_model dev (
    .clk(ref_clk), .pin(pin), .reg_addr(dev_reg_addr), .reg_wdata(dev_reg_wdata),
    .reg_we(dev_reg_we), .reg_re(dev_reg_re), .reg_rdata(dev_reg_rdata),
    .flash_addr(flash_addr), .flash_re(flash_re), .flash_rdata(flash_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_word(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic check_dev(input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] device write exp %h got %h", exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    last = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20)
    begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] ad, input logic [32:0] exp, input logic [31:0] mask);
    rdq.push_back({exp[32], mask, exp[31:0]});
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      rd(flash_guard_pkg::OFS_STATUS, 33'h0, 32'h0);
      n++;
    end while (last[b] !== v && n < 100);
    if (n >= 100)
    begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [1:0] r, input logic [7:0] dv,
                     input logic [15:0] ad, input logic refused);
    if (!refused && op == flash_guard_pkg::OP_REG_WR)
      devq.push_back({r, dv});
    if (!refused && op == flash_guard_pkg::OP_REG_WR && r == 2'h0)
      fcr = dv;
    if (!refused && op == flash_guard_pkg::OP_PROGRAM)
    begin
      fcr = fcr | (8'h01 << flash_guard_pkg::PROG_BIT);
      devq.push_back({2'h0, fcr});
    end
    apb(1'b1, flash_guard_pkg::OFS_CMD, {ad, dv, 4'h0, r, op});
    wait_st(flash_guard_pkg::ST_BUSY_BIT, 1'b0);
    rd(flash_guard_pkg::OFS_STATUS, 33'(refused) << flash_guard_pkg::ST_REFUSED_BIT,
       32'h1 << flash_guard_pkg::ST_REFUSED_BIT);
    if (refused)
      apb(1'b1, flash_guard_pkg::OFS_STATUS, 32'h1 << flash_guard_pkg::ST_REFUSED_BIT);
  endtask

  function automatic logic [7:0] fb(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction

  always @(posedge ref_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0)
    begin
      e = rdq.pop_front();
      if (e[63:32] != 32'h0)
        check_word("PRDATA", {e[64], e[31:0] & e[63:32]}, {pslverr, prdata & e[63:32]});
    end
    if (dev_reg_we === 1'b1)
    begin
      if (devq.size() == 0)
      begin
        errors++;
        $display("[ERR] device write exp none got %h", {dev_reg_addr, dev_reg_wdata});
      end
      else
        check_dev(devq.pop_front(), {dev_reg_addr, dev_reg_wdata});
    end
    // masks must bracket every pin edge
    if (rst_n === 1'b1 && pin !== prev_pin)
    begin
      check_word("IRQ_MASK_ALL", 33'h1, {32'h0, irq_mask});
      check_word("BUS_RELEASE_DISABLE", 33'h1, {32'h0, bus_dis});
      if (pin === 1'b0)
        check_word("ctrl one at pin drop", 33'h0, {25'h0, dev.regs[0]});
    end
    prev_pin <= pin;
  end

  initial
  begin
    {psel, penable, pwrite, flash_exec, prev_pin} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fcr = 8'h00;
    errors = 0;
    checks_done = 0;
    seed = 32'hA3AC;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(flash_guard_pkg::OFS_STATUS, 33'h0, 32'hFFFFFFFF);
    rd(flash_guard_pkg::OFS_SHADOW, 33'h0, 32'hFFFFFFFF);
    apb(1'b1, 8'h10, 32'h1);
    rd(8'h10, 33'h1_0000_0000, 32'hFFFFFFFF);
    rd(flash_guard_pkg::OFS_CTRL, 33'h0, 32'hFFFFFFFF);
    cmd(2'h0, 2'h0, 8'h40, 16'h0, 1'b1);
    $display("test reset and refusal done");
    apb(1'b1, flash_guard_pkg::OFS_CTRL, 32'h1);
    wait_st(flash_guard_pkg::ST_PIN_BIT, 1'b1);
    flash_exec <= 1'b1;
    cmd(2'h0, 2'h0, 8'h40, 16'h0, 1'b1);
    flash_exec <= 1'b0;
    cmd(2'h0, 2'h0, 8'h40, 16'h0, 1'b0);
    rd(flash_guard_pkg::OFS_SHADOW, 33'h40, 32'hFF);
    a = 16'($random(seed));
    cmd(2'h2, 2'h0, 8'h00, a, 1'b1);
    $display("test enable and rewrite done");
    cmd(2'h3, 2'h0, 8'h00, a, 1'b0);
    cmd(2'h2, 2'h0, 8'h00, a, 1'b1);
    cmd(2'h0, 2'h0, 8'h40, 16'h0, 1'b0);
    rd(flash_guard_pkg::OFS_STATUS, 33'h8, 32'h8);
    cmd(2'h0, 2'h0, 8'h44, 16'h0, 1'b0);
    cmd(2'h2, 2'h0, 8'h00, a, 1'b1);
    wait_st(flash_guard_pkg::ST_WAIT_BIT, 1'b0);
    cmd(2'h2, 2'h0, 8'h00, a, 1'b0);
    rd(flash_guard_pkg::OFS_STATUS, {17'h0, fb(a), 8'h0}, 32'hFF00);
    cmd(2'h3, 2'h0, 8'h00, a ^ 16'h0005, 1'b1);
    cmd(2'h3, 2'h0, 8'h00, a ^ 16'h0080, 1'b0);
    cmd(2'h0, 2'h0, 8'h42, 16'h0, 1'b0);
    cmd(2'h3, 2'h0, 8'h00, a, 1'b0);
    $display("test program and verify done");
    d = 8'($random(seed));
    cmd(2'h0, 2'h2, d, 16'h0, 1'b0);
    cmd(2'h1, 2'h2, 8'h00, 16'h0, 1'b0);
    rd(flash_guard_pkg::OFS_STATUS, {17'h0, d, 8'h0}, 32'hFF00);
    $display("test byte register access done");
    flash_exec <= 1'b1;
    cmd(2'h0, 2'h0, 8'h00, 16'h0, 1'b1);
    flash_exec <= 1'b0;
    cmd(2'h0, 2'h0, 8'h00, 16'h0, 1'b0);
    apb(1'b1, flash_guard_pkg::OFS_CTRL, 32'h0);
    wait_st(flash_guard_pkg::ST_PIN_BIT, 1'b0);
    wait_st(flash_guard_pkg::ST_WAIT_BIT, 1'b0);
    cmd(2'h2, 2'h0, 8'h00, a ^ 16'h0100, 1'b0);
    rd(flash_guard_pkg::OFS_STATUS, {17'h0, fb(a ^ 16'h0100), 8'h0}, 32'hFF00);
    $display("test shutdown done");
    print_verdict();
  end
endmodule // flash_program_erase_guard_bench
